/* verilog/hsq_pkg.sv */
/*
  Shared constants and types for the homing sequencer.
  Assumes a single 10 MHz control clock and synchronous inputs.
*/
package hsq_pkg;

  localparam int          HSQ_CLK_HZ      = 10000000;
  localparam int          HSQ_SPEED_W     = 16;
  localparam int          HSQ_METHOD_W    = 8;

  // homing method codes handled by this block
  localparam logic [7:0]  HSQ_M9          = 8'h09;
  localparam logic [7:0]  HSQ_M10         = 8'h0A;
  localparam logic [7:0]  HSQ_M11         = 8'h0B;
  localparam logic [7:0]  HSQ_M12         = 8'h0C;
  localparam logic [7:0]  HSQ_M13         = 8'h0D;
  localparam logic [7:0]  HSQ_M14         = 8'h0E;
  localparam logic [7:0]  HSQ_M17         = 8'h11;
  localparam logic [7:0]  HSQ_M18         = 8'h12;
  localparam logic [7:0]  HSQ_M19         = 8'h13;

  localparam logic        HSQ_DIR_POS     = 1'b0;
  localparam logic        HSQ_DIR_NEG     = 1'b1;
  localparam logic [15:0] HSQ_SPEED_ZERO  = 16'h0000;

  // which reference a method watches, and how it ends
  typedef enum logic [1:0] {
    HSQ_SRC_HOME,
    HSQ_SRC_NLIM,
    HSQ_SRC_PLIM
  } hsq_src_t;

  // one step of a homing plan: the motion while waiting, and the wait
  typedef enum logic [2:0] {
    HSQ_W_RISE,
    HSQ_W_FALL,
    HSQ_W_INDEX,
    HSQ_W_DONE
  } hsq_wait_t;

endpackage

/* verilog/hsq_edge_detect.sv */
/*
  Rising and falling edge detector for one level input.
  Assumes the input is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module hsq_edge_detect
  import hsq_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic last;
  } hsq_ed_state_t;

  hsq_ed_state_t state_reg;
  hsq_ed_state_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.last = level;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rise = level & ~state_reg.last;
  assign fall = ~level & state_reg.last;

endmodule // hsq_edge_detect

/* verilog/hsq_speed_select.sv */
/*
  Maps the requested speed class onto the configured search speeds.
  Assumes the two speed settings are held steady during a homing run.
*/
`timescale 1ns/1ps
module hsq_speed_select
  import hsq_pkg::*;
(
  input  wire logic [15:0] switchSpeed,
  input  wire logic [15:0] zeroSpeed,
  input  wire logic        running,
  input  wire logic        highSel,
  output logic [15:0]      speedCmd
);

  always_comb begin
    if (!running) begin
      speedCmd = HSQ_SPEED_ZERO;
    end else if (highSel) begin
      speedCmd = switchSpeed; // R18
    end else begin
      speedCmd = zeroSpeed; // R18
    end
  end

endmodule // hsq_speed_select

/* verilog/hsq_homing_seq.sv */
/*
  Homing sequencer for methods 9 to 14 and 17 to 19.
  Assumes limit, home switch and index inputs synchronous to ref_clk,
  active high, and the motion loop following dirCmd/speedCmd.
*/
`timescale 1ns/1ps
// Notes on behaviour
// R1: method 9: fast positive, slow on rise, reverse, index
// R2: 9/10 positive limit: reverse fast, then positive slow
// R3: 9/12 switch active: slow, reverse at fall, index
// R4: method 10: keep positive after fall, index
// R5: 10/11 switch active: positive slow, index after fall
// R6: method 11: fast negative, positive slow at edge
// R7: 11-14 negative limit: reverse fast positive
// R8: 11/12 after limit: slow on rise, 12 reverses
// R9: method 13: fast negative, slow, reverse at fall
// R10: 13 after limit: negative slow, positive at fall
// R11: 13 switch active: negative slow, reverse, index
// R12: method 14: fast negative, slow, keep negative
// R13: 14 after limit: negative slow on rise
// R14: 14 switch active: negative slow, index after fall
// R15: method 17: negative limit edges, no index
// R16: method 18: positive limit edges, no index
// R17: method 19: home switch edges, no index
// R18: fast from switch speed, slow from zero speed
// R19: method codes 9,10,11,12,13,14,17,18,19 as ordered
// R20: at stop, zero speed and homing done
module hsq_homing_seq
  import hsq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        homeStart,
  input  wire logic [7:0]  homeMethod,
  input  wire logic [15:0] switchSpeed,
  input  wire logic [15:0] zeroSpeed,
  input  wire logic        homeSwitch,
  input  wire logic        negative_travel_limit,
  input  wire logic        positive_travel_limit,
  input  wire logic        indexPulse,
  output logic             dirCmd,
  output logic [15:0]      speedCmd,
  output logic             homeBusy,
  output logic             homeDone,
  output logic             methodError
);

  typedef enum logic [1:0] {
    HSQ_IDLE,
    HSQ_RUN,
    HSQ_DONE
  } hsq_phase_t;

  typedef struct packed {
    hsq_phase_t phase;
    logic [7:0] method;
    logic       dir;
    logic       high;
    hsq_wait_t  waitFor;
    logic [1:0] step;
    logic       limitPath;
    logic       err;
  } hsq_state_t;

  hsq_state_t state_reg;
  hsq_state_t state_next;

  logic homeRise;
  logic homeFall;
  logic nRise;
  logic nFall;
  logic pRise;
  logic pFall;
  logic refRise;
  logic refFall;
  logic refLevel;

  hsq_edge_detect uHome (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (homeSwitch),
    .rise    (homeRise),
    .fall    (homeFall)
  );

  hsq_edge_detect uNeg (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (negative_travel_limit),
    .rise    (nRise),
    .fall    (nFall)
  );

  hsq_edge_detect uPos (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .level   (positive_travel_limit),
    .rise    (pRise),
    .fall    (pFall)
  );

  function automatic logic isKnown(input logic [7:0] m);
    isKnown = (m == HSQ_M9)  || (m == HSQ_M10) || (m == HSQ_M11) ||
              (m == HSQ_M12) || (m == HSQ_M13) || (m == HSQ_M14) ||
              (m == HSQ_M17) || (m == HSQ_M18) || (m == HSQ_M19); // R19
  endfunction

  // reference watched by the current method
  always_comb begin
    unique case (state_reg.method)
      HSQ_M17: begin
        refRise  = nRise;
        refFall  = nFall;
        refLevel = negative_travel_limit;
      end
      HSQ_M18: begin
        refRise  = pRise;
        refFall  = pFall;
        refLevel = positive_travel_limit;
      end
      default: begin
        refRise  = homeRise;
        refFall  = homeFall;
        refLevel = homeSwitch;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg.phase)
      HSQ_IDLE, HSQ_DONE: begin
        if (homeStart) begin
          state_next.method    = homeMethod;
          state_next.limitPath = 1'b0;
          // 2 marks a fast start, 0 a start on the switch
          state_next.step      = 2'h2;
          state_next.err       = ~isKnown(homeMethod);
          state_next.phase     = isKnown(homeMethod) ? HSQ_RUN : HSQ_IDLE;
          state_next.waitFor   = HSQ_W_RISE;
          state_next.high      = 1'b1;
          // start plan chosen from the reference level at start
          unique case (homeMethod)
            HSQ_M9, HSQ_M10: begin
              state_next.dir  = HSQ_DIR_POS; // R1
              if (homeSwitch) begin
                state_next.high    = 1'b0; // R3 R5
                state_next.waitFor = HSQ_W_FALL;
                state_next.step    = 2'h0;
              end
            end
            HSQ_M11, HSQ_M12, HSQ_M13, HSQ_M14: begin
              state_next.dir = HSQ_DIR_NEG; // R6 R8 R9 R12
              if (homeSwitch) begin
                state_next.high    = 1'b0;
                state_next.waitFor = HSQ_W_FALL;
                state_next.step    = 2'h0;
                state_next.dir     = (homeMethod == HSQ_M11 ||
                                      homeMethod == HSQ_M12)
                                     ? HSQ_DIR_POS : HSQ_DIR_NEG; // R3 R5 R11 R14
              end
            end
            HSQ_M17: begin
              state_next.dir = HSQ_DIR_NEG; // R15
              if (negative_travel_limit) begin
                state_next.dir     = HSQ_DIR_POS; // R15
                state_next.high    = 1'b0;
                state_next.waitFor = HSQ_W_FALL;
              end
            end
            HSQ_M18: begin
              state_next.dir = HSQ_DIR_POS; // R16
              if (positive_travel_limit) begin
                state_next.dir     = HSQ_DIR_NEG; // R16
                state_next.high    = 1'b0;
                state_next.waitFor = HSQ_W_FALL;
              end
            end
            default: begin
              state_next.dir = HSQ_DIR_POS; // R17
              if (homeSwitch) begin
                state_next.dir     = HSQ_DIR_NEG; // R17
                state_next.high    = 1'b0;
                state_next.waitFor = HSQ_W_FALL;
              end
            end
          endcase
        end
      end
      HSQ_RUN: begin
        // limit reversal during the fast search
        if (state_reg.high && state_reg.waitFor == HSQ_W_RISE &&
            !state_reg.limitPath) begin
          if ((state_reg.method == HSQ_M9 || state_reg.method == HSQ_M10)
              && pRise) begin
            state_next.dir       = HSQ_DIR_NEG; // R2
            state_next.limitPath = 1'b1;
          end
          if ((state_reg.method == HSQ_M11 || state_reg.method == HSQ_M12 ||
               state_reg.method == HSQ_M13 || state_reg.method == HSQ_M14)
              && nRise) begin
            state_next.dir       = HSQ_DIR_POS; // R7
            state_next.limitPath = 1'b1;
          end
        end
        unique case (state_reg.waitFor)
          HSQ_W_RISE: begin
            if (refRise) begin
              state_next.high    = 1'b0;
              state_next.waitFor = HSQ_W_FALL;
              unique case (state_reg.method)
                HSQ_M9, HSQ_M10: begin
                  if (state_reg.step == 2'h1) begin
                    state_next.waitFor = HSQ_W_INDEX; // R3
                  end else begin
                    state_next.dir = HSQ_DIR_POS; // R1 R2
                  end
                end
                HSQ_M11: state_next.dir = HSQ_DIR_POS; // R6 R8
                HSQ_M12: begin
                  if (state_reg.step == 2'h1) begin
                    state_next.waitFor = HSQ_W_INDEX;
                  end else begin
                    state_next.dir = HSQ_DIR_POS; // R8
                  end
                end
                HSQ_M13: begin
                  if (state_reg.step == 2'h1) begin
                    state_next.waitFor = HSQ_W_INDEX; // R11
                  end else begin
                    state_next.dir = HSQ_DIR_NEG; // R9 R10
                  end
                end
                HSQ_M14: state_next.dir = HSQ_DIR_NEG; // R12 R13
                default: begin
                  state_next.dir = ~state_reg.dir; // R15 R16 R17
                end
              endcase
            end
          end
          HSQ_W_FALL: begin
            if (refFall) begin
              unique case (state_reg.method)
                HSQ_M9, HSQ_M12, HSQ_M13: begin
                  if (state_reg.step == 2'h0 && state_reg.phase == HSQ_RUN
                      && state_reg.dir == (state_reg.method == HSQ_M13
                                           ? HSQ_DIR_NEG : HSQ_DIR_POS)
                      && !state_reg.high && !wasFastSearch()) begin
                    // started on the switch: reverse, then wait for rise
                    state_next.dir     = ~state_reg.dir; // R3 R11
                    state_next.step    = 2'h1;
                    state_next.waitFor = HSQ_W_RISE;
                  end else begin
                    state_next.dir     = (state_reg.method == HSQ_M13)
                                         ? HSQ_DIR_POS : HSQ_DIR_NEG;
                    state_next.waitFor = HSQ_W_INDEX; // R1 R9 R10
                  end
                end
                HSQ_M10, HSQ_M11, HSQ_M14:
                  state_next.waitFor = HSQ_W_INDEX; // R4 R5 R6 R14
                default:
                  state_next.waitFor = HSQ_W_DONE; // R15 R16 R17
              endcase
            end
          end
          HSQ_W_INDEX: begin
            if (indexPulse) begin
              state_next.waitFor = HSQ_W_DONE;
            end
          end
          default: begin
          end
        endcase
        if (state_next.waitFor == HSQ_W_DONE) begin
          state_next.phase = HSQ_DONE; // R20
        end
      end
      default: begin
        state_next.phase = HSQ_IDLE;
      end
    endcase
  end

  // a fast start sets step 2 and a limit sets limitPath, so a falling
  // edge after a slow-down is never taken for a start on the switch
  function automatic logic wasFastSearch();
    wasFastSearch = state_reg.limitPath | state_reg.step[1];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= '{phase: HSQ_IDLE, method: 8'h00, dir: HSQ_DIR_POS,
                     high: 1'b0, waitFor: HSQ_W_DONE, step: 2'h0,
                     limitPath: 1'b0, err: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  hsq_speed_select uSpeed (
    .switchSpeed (switchSpeed),
    .zeroSpeed   (zeroSpeed),
    .running     (state_reg.phase == HSQ_RUN),
    .highSel     (state_reg.high),
    .speedCmd    (speedCmd)
  );

  assign dirCmd      = state_reg.dir;
  assign homeBusy    = (state_reg.phase == HSQ_RUN);
  assign homeDone    = (state_reg.phase == HSQ_DONE); // R20
  assign methodError = state_reg.err;

endmodule // hsq_homing_seq

/* tb/hsq_asserts.sv */
/*
  Port-level assertions for the homing sequencer.
  Assumes one ref_clk domain; bound to every hsq_homing_seq.
*/
`timescale 1ns/1ps
module hsq_asserts
  import hsq_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        homeStart,
  input wire logic [7:0]  homeMethod,
  input wire logic [15:0] switchSpeed,
  input wire logic [15:0] zeroSpeed,
  input wire logic        homeSwitch,
  input wire logic        negative_travel_limit,
  input wire logic        positive_travel_limit,
  input wire logic        dirCmd,
  input wire logic [15:0] speedCmd,
  input wire logic        homeBusy,
  input wire logic        homeDone,
  input wire logic        methodError
);
  logic validCode;
  assign validCode = homeMethod inside {HSQ_M9, HSQ_M10, HSQ_M11, HSQ_M12,
    HSQ_M13, HSQ_M14, HSQ_M17, HSQ_M18, HSQ_M19};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_idle_speed_zero: assert property (!homeBusy |-> speedCmd == 16'h0000)
    else $error("speed commanded while idle");
  a_speed_source: assert property (homeBusy |->
    speedCmd == switchSpeed || speedCmd == zeroSpeed)
    else $error("speed not from a setting");
  a_start_runs: assert property (homeStart && !homeBusy && validCode
    |=> homeBusy && !methodError) else $error("valid start not taken");
  a_bad_code: assert property (homeStart && !homeBusy && !validCode
    |=> methodError && !homeBusy) else $error("unknown code not refused");
  a_stop_done: assert property ($fell(homeBusy) |->
    homeDone && speedCmd == 16'h0000) else $error("stop without done");
  a_done_holds: assert property (homeDone && !homeStart |=> homeDone)
    else $error("done dropped");
  a_nlim_start: assert property ($rose(homeBusy) &&
    $past(homeMethod) == HSQ_M17 |-> dirCmd == !$past(negative_travel_limit)
    && speedCmd == ($past(negative_travel_limit) ? zeroSpeed : switchSpeed))
    else $error("method 17 start wrong");
  a_plim_start: assert property ($rose(homeBusy) &&
    $past(homeMethod) == HSQ_M18 |-> dirCmd == $past(positive_travel_limit)
    && speedCmd == ($past(positive_travel_limit) ? zeroSpeed : switchSpeed))
    else $error("method 18 start wrong");
  a_switch_start: assert property ($rose(homeBusy) &&
    $past(homeMethod) == HSQ_M19 |-> dirCmd == $past(homeSwitch)
    && speedCmd == ($past(homeSwitch) ? zeroSpeed : switchSpeed))
    else $error("method 19 start wrong");
endmodule // hsq_asserts

bind hsq_homing_seq hsq_asserts chk_u (.ref_clk(ref_clk), .rst_b(rst_b),
  .homeStart(homeStart), .homeMethod(homeMethod), .switchSpeed(switchSpeed),
  .zeroSpeed(zeroSpeed), .homeSwitch(homeSwitch),
  .negative_travel_limit(negative_travel_limit),
  .positive_travel_limit(positive_travel_limit), .dirCmd(dirCmd),
  .speedCmd(speedCmd), .homeBusy(homeBusy), .homeDone(homeDone),
  .methodError(methodError));

/* tb/hsq_axis_model.sv */
/*
  Axis model: position follows the commands, switches decode position.
  Assumes one position step per clock while any speed is commanded.
*/
`timescale 1ns/1ps
module hsq_axis_model
  import hsq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        loadEn,
  input  wire logic [15:0] loadPos,
  input  wire logic        dirCmd,
  input  wire logic [15:0] speedCmd,
  output logic             homeSwitch,
  output logic             nLimit,
  output logic             pLimit,
  output logic             indexPulse,
  output logic [15:0]      axisPos
);
  initial axisPos = 16'h0032;
  always @(posedge ref_clk) begin
    if (loadEn)
      axisPos <= loadPos;
    else if (speedCmd != HSQ_SPEED_ZERO)
      axisPos <= (dirCmd == HSQ_DIR_NEG) ? axisPos - 16'h0001
                                         : axisPos + 16'h0001;
  end
  // rate ignores speed: only the order of edges matters here
  assign homeSwitch = axisPos >= 16'h008C && axisPos <= 16'h00AA;
  assign nLimit     = axisPos <= 16'h000A;
  assign pLimit     = axisPos >= 16'h012C;
  // one-position index mark, so a late stop shows as wrong position
  assign indexPulse = axisPos[4:0] == 5'h00;
endmodule // hsq_axis_model

/* tb/hsq_homing_seq_tb_top.sv */
/*
  Self-checking bench for the homing sequencer with an axis model.
  Assumes the bound checker and 10 MHz ref_clk.
*/
`timescale 1ns/1ps
module hsq_homing_seq_tb_top;
  import hsq_pkg::*;
  logic ref_clk, rst_b, homeStart, loadEn, homeSwitch, nLimit, pLimit;
  logic indexPulse, dirCmd, homeBusy, homeDone, methodError;
  logic [7:0]  homeMethod;
  logic [15:0] switchSpeed, zeroSpeed, speedCmd, loadPos, axisPos, trace;
  logic [3:0]  code, lastCode;
  int          fail_count, samples_checked;
  hsq_homing_seq dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
    .homeStart(homeStart), .homeMethod(homeMethod),
    .switchSpeed(switchSpeed), .zeroSpeed(zeroSpeed),
    .homeSwitch(homeSwitch), .negative_travel_limit(nLimit),
    .positive_travel_limit(pLimit), .indexPulse(indexPulse),
    .dirCmd(dirCmd), .speedCmd(speedCmd), .homeBusy(homeBusy),
    .homeDone(homeDone), .methodError(methodError));
  hsq_axis_model axis_u (.ref_clk(ref_clk), .loadEn(loadEn),
    .loadPos(loadPos), .dirCmd(dirCmd), .speedCmd(speedCmd),
    .homeSwitch(homeSwitch), .nLimit(nLimit), .pLimit(pLimit),
    .indexPulse(indexPulse), .axisPos(axisPos));
  always #50 ref_clk = ~ref_clk;
  // segment log, one hex digit each: 5 +fast, 4 +slow, 7 -fast, 6 -slow
  always @(negedge ref_clk) begin
    if (speedCmd !== HSQ_SPEED_ZERO) begin
      code = (speedCmd === switchSpeed) ? {2'b01, dirCmd, 1'b1} :
             (speedCmd === zeroSpeed) ? {2'b01, dirCmd, 1'b0} : 4'hF;
      if (code !== lastCode) begin
        trace = {trace[11:0], code};
        lastCode = code;
      end
    end
  end
  task tick;
    @(posedge ref_clk);
    #10;
  endtask
  task check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task run_case(input logic [7:0] m, input logic [15:0] p, expTr, expStop);
    int n;
    logic [15:0] d;
    tick;
    homeMethod = m;
    loadPos = p;
    loadEn = 1'b1;
    tick;
    loadEn = 1'b0;
    // edge detectors need settled inputs before the start
    tick;
    tick;
    trace = 16'h0000;
    lastCode = 4'h0;
    homeStart = 1'b1;
    tick;
    homeStart = 1'b0;
    n = 0;
    while (homeDone !== 1'b1 && n < 3000) begin
      tick;
      n++;
    end
    check("done in time", {15'h0000, homeDone}, 16'h0001);
    d = (axisPos > expStop) ? axisPos - expStop : expStop - axisPos;
    check("segments", trace, expTr);
    check("stop place", {15'h0000, d <= 16'h0004}, 16'h0001);
    check("stop speed", speedCmd, HSQ_SPEED_ZERO);
    check("busy after", {15'h0000, homeBusy}, 16'h0000);
  endtask
  task t_method9;
    run_case(HSQ_M9, 16'h0032, 16'h0546, 16'h00A0);
    run_case(HSQ_M9, 16'h00C8, 16'h5746, 16'h00A0);
    run_case(HSQ_M9, 16'h0096, 16'h0046, 16'h00A0);
    $display("test method9 done");
  endtask
  task t_method10;
    run_case(HSQ_M10, 16'h0032, 16'h0054, 16'h00C0);
    run_case(HSQ_M10, 16'h00C8, 16'h0574, 16'h00C0);
    run_case(HSQ_M10, 16'h0096, 16'h0004, 16'h00C0);
    $display("test method10 done");
  endtask
  task t_method11_12;
    run_case(HSQ_M11, 16'h00FA, 16'h0074, 16'h00C0);
    run_case(HSQ_M11, 16'h0064, 16'h0754, 16'h00C0);
    run_case(HSQ_M11, 16'h0096, 16'h0004, 16'h00C0);
    run_case(HSQ_M12, 16'h00FA, 16'h0746, 16'h00A0);
    run_case(HSQ_M12, 16'h0064, 16'h7546, 16'h00A0);
    run_case(HSQ_M12, 16'h0096, 16'h0046, 16'h00A0);
    $display("test method11_12 done");
  endtask
  task t_method13_14;
    run_case(HSQ_M13, 16'h00FA, 16'h0764, 16'h00A0);
    run_case(HSQ_M13, 16'h0064, 16'h7564, 16'h00A0);
    run_case(HSQ_M13, 16'h0096, 16'h0064, 16'h00A0);
    run_case(HSQ_M14, 16'h00FA, 16'h0076, 16'h0080);
    run_case(HSQ_M14, 16'h0064, 16'h0756, 16'h0080);
    run_case(HSQ_M14, 16'h0096, 16'h0006, 16'h0080);
    $display("test method13_14 done");
  endtask
  task t_edge_home;
    run_case(HSQ_M17, 16'h0064, 16'h0074, 16'h000B);
    run_case(HSQ_M17, 16'h0005, 16'h0004, 16'h000B);
    run_case(HSQ_M18, 16'h00FA, 16'h0056, 16'h012B);
    run_case(HSQ_M18, 16'h0131, 16'h0006, 16'h012B);
    run_case(HSQ_M19, 16'h0032, 16'h0056, 16'h008B);
    run_case(HSQ_M19, 16'h0096, 16'h0006, 16'h008B);
    $display("test edge_home done");
  endtask
  task t_bad_code;
    tick;
    homeMethod = 8'h0F;
    homeStart = 1'b1;
    tick;
    homeStart = 1'b0;
    tick;
    check("error flag", {15'h0000, methodError}, 16'h0001);
    check("busy on bad", {15'h0000, homeBusy}, 16'h0000);
    run_case(HSQ_M19, 16'h0032, 16'h0056, 16'h008B);
    check("error clear", {15'h0000, methodError}, 16'h0000);
    $display("test bad_code done");
  endtask
  initial begin
    #4000000;
    fail_count++;
    wrap_up;
  end
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    homeStart = 1'b0;
    homeMethod = HSQ_M9;
    switchSpeed = 16'h0300;
    zeroSpeed = 16'h0040;
    loadEn = 1'b0;
    loadPos = 16'h0032;
    trace = 16'h0000;
    lastCode = 4'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    #10;
    rst_b = 1'b1;
    t_method9;
    t_method10;
    t_method11_12;
    t_method13_14;
    t_edge_home;
    t_bad_code;
    wrap_up;
  end
endmodule // hsq_homing_seq_tb_top
